// >>> verilog/ssa_pkg.sv
package ssa_pkg;
   // Frame layout
   localparam int          FRAME_BITS      = 32;
   localparam logic [5:0]  FRAME_COUNT     = 6'h20;
   localparam int          ADDR_MSB        = 31;
   localparam int          ADDR_LSB        = 25;
   localparam int          RW_BIT          = 24;
   localparam int          DATA_W          = 24;
   localparam int          HDR_LSB         = 24;
   localparam int          FAULT_SUM_BIT   = 23;
   localparam int          INT_FLAG_BIT    = 22;
   localparam int          SP_LSB          = 14;
   localparam int          SG_LSB          = 0;
   localparam int          NUM_SG          = 14;
   localparam int          NUM_SP          = 8;
   localparam int          NUM_INPUTS      = 22;

   // Command addresses
   localparam logic [6:0]  ADDR_ANALOG_MUX_OUTPUT       = 7'h1D;
   localparam logic [6:0]  ADDR_SWITCH     = 7'h1F;
   localparam logic [6:0]  ADDR_FAULT      = 7'h21;
   localparam logic [6:0]  ADDR_LINK_CHECK = 7'h01;
   localparam logic [6:0]  ADDR_WET_CFG0   = 7'h02;
   localparam logic [6:0]  ADDR_WET_CFG1   = 7'h03;

   // Analog mux select fields
   localparam int          ANALOG_MUX_OUTPUT_CODE_LSB   = 0;
   localparam int          ANALOG_MUX_OUTPUT_CODE_W     = 6;
   localparam int          ANALOG_MUX_OUTPUT_SRC_BIT    = 6;
   localparam int          ANALOG_MUX_OUTPUT_REG_W      = 7;
   localparam logic [6:0]  ANALOG_MUX_OUTPUT_RESET      = 7'h00;
   localparam logic [5:0]  ANALOG_MUX_OUTPUT_CODE_NONE  = 6'h00;
   localparam logic [5:0]  ANALOG_MUX_OUTPUT_CODE_MAX   = 6'h16;

   // Fault sources
   localparam int          EXT_W           = 11;
   localparam int          WET_W           = 22;

   // Interrupt pin release time
   localparam int          CLK_KHZ         = 40000;
   localparam int          INT_RELEASE_US  = 1000;
   localparam int          INT_RELEASE_CYC = (INT_RELEASE_US * CLK_KHZ) / 1000;
   localparam int          TIMER_W         = 16;
endpackage : ssa_pkg

// >>> verilog/ssa_frame_if.sv
interface ssa_frame_if;
   logic        cs_fall;
   logic        frame_done;
   logic        frame_ok;
   logic [31:0] rx_word;
   logic [31:0] tx_word;

   modport shifter (
      output cs_fall,
      output frame_done,
      output frame_ok,
      output rx_word,
      input  tx_word
   );
   modport core (
      input  cs_fall,
      input  frame_done,
      input  frame_ok,
      input  rx_word,
      output tx_word
   );
endinterface : ssa_frame_if

// >>> verilog/ssa_sync.sv
module ssa_sync #(
   parameter int          W         = 1,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Data
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);
   logic [W-1:0] stage1;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         stage1 <= RESET_VAL;
         q_o    <= RESET_VAL;
      end else begin
         stage1 <= d_i;
         q_o    <= stage1;
      end
   end
endmodule : ssa_sync

// >>> verilog/ssa_spi_shift.sv
module ssa_spi_shift (
   // Clock and reset
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   // Synchronised link pins
   input  wire logic  sclk_i,
   input  wire logic  cs_n_i,
   input  wire logic  mosi_i,
   output logic       miso_o,
   // Frame side
   ssa_frame_if.shifter frm
);
   logic        cs_prev;
   logic        sclk_prev;
   logic [5:0]  bit_count;
   logic [31:0] rx_sh;
   logic [31:0] tx_sh;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        cs_rise;

   assign sclk_rise = ~sclk_prev & sclk_i & ~cs_n_i;
   assign sclk_fall = sclk_prev & ~sclk_i & ~cs_n_i;
   assign cs_rise   = ~cs_prev & cs_n_i;
   assign miso_o    = tx_sh[ssa_pkg::FRAME_BITS-1];

   // Edge history
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cs_prev   <= 1'b1;
         sclk_prev <= 1'b0;
      end else begin
         cs_prev   <= cs_n_i;
         sclk_prev <= sclk_i;
      end
   end

   // Receive side, MSB first on rising serial clock
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_sh     <= 32'h0000_0000;
         bit_count <= 6'h00;
      end else if (frm.cs_fall) begin
         bit_count <= 6'h00;
      end else if (sclk_rise) begin
         rx_sh <= {rx_sh[30:0], mosi_i};
         if (bit_count <= ssa_pkg::FRAME_COUNT) begin
            bit_count <= bit_count + 6'h01;
         end
      end
   end

   // Transmit side, changes on falling serial clock
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_sh <= 32'h0000_0000;
      end else if (frm.cs_fall) begin
         tx_sh <= frm.tx_word;
      end else if (sclk_fall) begin
         tx_sh <= {tx_sh[30:0], 1'b0};
      end
   end

   // Frame markers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         frm.cs_fall    <= 1'b0;
         frm.frame_done <= 1'b0;
         frm.frame_ok   <= 1'b0;
         frm.rx_word    <= 32'h0000_0000;
      end else begin
         frm.cs_fall    <= cs_prev & ~cs_n_i;
         frm.frame_done <= cs_rise;
         if (cs_rise) begin
            frm.frame_ok <= (bit_count == ssa_pkg::FRAME_COUNT);
            frm.rx_word  <= rx_sh;
         end
      end
   end
endmodule : ssa_spi_shift

// >>> verilog/ssa_switch_status.sv
module ssa_switch_status #(
   parameter int unsigned INT_RELEASE_CYCLES = ssa_pkg::INT_RELEASE_CYC
) (
   // Clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   // Serial link pins
   input  wire logic                          sclk_i,
   input  wire logic                          cs_n_i,
   input  wire logic                          mosi_i,
   output logic                               miso_o,
   output logic                               miso_oe_o,
   // Switch inputs, 1 when closed
   input  wire logic [ssa_pkg::NUM_INPUTS-1:0] switch_closed_i,
   // Fault flags from the fault register
   input  wire logic [ssa_pkg::EXT_W-1:0]      ext_status_i,
   input  wire logic [ssa_pkg::WET_W-1:0]      wet_fault_i,
   output logic                               fault_read_o,
   // Analog mux control
   output logic [ssa_pkg::ANALOG_MUX_OUTPUT_CODE_W-1:0]     analog_mux_channel_o,
   output logic                               analog_source_choice_o,
   // Interrupt pin
   output logic                               int_n_o
);
   ssa_frame_if frm ();

   logic                            sclk_s;
   logic                            cs_n_s;
   logic                            mosi_s;
   logic [ssa_pkg::NUM_INPUTS-1:0]  sw_s;
   logic [ssa_pkg::NUM_INPUTS-1:0]  sw_prev;
   logic [ssa_pkg::EXT_W+ssa_pkg::WET_W-1:0] fault_vec;
   logic [ssa_pkg::EXT_W+ssa_pkg::WET_W-1:0] fault_prev;
   logic [ssa_pkg::ANALOG_MUX_OUTPUT_REG_W-1:0]  analog_mux_select;
   logic [ssa_pkg::ANALOG_MUX_OUTPUT_CODE_W-1:0] analog_mux_output_code;
   logic                            por_flag;
   logic                            int_flag;
   logic                            int_active;
   logic                            timer_run;
   logic [ssa_pkg::TIMER_W-1:0]     timer;
   logic [31:0]                     tx_word;
   logic [6:0]                      cmd_addr;
   logic                            cmd_write;
   logic                            cmd_valid;
   logic                            carries_flags;
   logic                            int_event;
   logic                            fault_summary;
   logic [ssa_pkg::NUM_INPUTS-1:0]  sw_masked;
   logic [ssa_pkg::NUM_INPUTS-1:0]  sel_mask;
   logic [ssa_pkg::DATA_W-1:0]      next_data;

   // Pin synchronisers
   ssa_sync #(
      .W         (3),
      .RESET_VAL (3'h2)
   ) u_pin_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({sclk_i, cs_n_i, mosi_i}),
      .q_o   ({sclk_s, cs_n_s, mosi_s})
   );

   ssa_sync #(
      .W         (ssa_pkg::NUM_INPUTS),
      .RESET_VAL (22'h00_0000)
   ) u_sw_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (switch_closed_i),
      .q_o   (sw_s)
   );

   // Serial shifter
   ssa_spi_shift u_shift (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .sclk_i (sclk_s),
      .cs_n_i (cs_n_s),
      .mosi_i (mosi_s),
      .miso_o (miso_o),
      .frm    (frm.shifter)
   );

   assign frm.tx_word = tx_word;
   assign miso_oe_o   = ~cs_n_s;

   // Command decode
   assign cmd_addr      = frm.rx_word[ssa_pkg::ADDR_MSB:ssa_pkg::ADDR_LSB];
   assign cmd_write     = frm.rx_word[ssa_pkg::RW_BIT];
   assign cmd_valid     = frm.frame_done & frm.frame_ok;
   assign carries_flags = (cmd_addr != ssa_pkg::ADDR_LINK_CHECK)
                        & (cmd_addr != ssa_pkg::ADDR_WET_CFG0)
                        & (cmd_addr != ssa_pkg::ADDR_WET_CFG1);

   // Analog mux select register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         analog_mux_select <= ssa_pkg::ANALOG_MUX_OUTPUT_RESET;
      end else if (cmd_valid && cmd_write && cmd_addr == ssa_pkg::ADDR_ANALOG_MUX_OUTPUT) begin
         analog_mux_select <= frm.rx_word[ssa_pkg::ANALOG_MUX_OUTPUT_REG_W-1:0];
      end
   end

   // Out-of-range codes select nothing
   always_comb begin
      analog_mux_output_code = analog_mux_select[ssa_pkg::ANALOG_MUX_OUTPUT_CODE_LSB +: ssa_pkg::ANALOG_MUX_OUTPUT_CODE_W];
      if (analog_mux_output_code > ssa_pkg::ANALOG_MUX_OUTPUT_CODE_MAX) begin
         analog_mux_output_code = ssa_pkg::ANALOG_MUX_OUTPUT_CODE_NONE;
      end
   end

   assign analog_mux_channel_o   = analog_mux_output_code;
   assign analog_source_choice_o = analog_mux_select[ssa_pkg::ANALOG_MUX_OUTPUT_SRC_BIT];

   // Channel code n selects status bit n-1
   always_comb begin
      sel_mask = '0;
      if (analog_mux_output_code != ssa_pkg::ANALOG_MUX_OUTPUT_CODE_NONE) begin
         sel_mask[5'(analog_mux_output_code - 6'h01)] = 1'b1;
      end
   end

   assign sw_masked = sw_s & ~sel_mask;

   // Fault summary
   assign fault_vec     = {ext_status_i, wet_fault_i};
   assign fault_summary = por_flag | (|fault_vec);

   // Power-on flag, cleared by a fault register read
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         por_flag <= 1'b1;
      end else if (cmd_valid && !cmd_write && cmd_addr == ssa_pkg::ADDR_FAULT) begin
         por_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         fault_read_o <= 1'b0;
      end else begin
         fault_read_o <= cmd_valid & ~cmd_write & (cmd_addr == ssa_pkg::ADDR_FAULT);
      end
   end

   // Event history
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         sw_prev    <= '0;
         fault_prev <= '0;
      end else begin
         sw_prev    <= sw_s;
         fault_prev <= fault_vec;
      end
   end

   assign int_event = (|(sw_s ^ sw_prev)) | (|(fault_vec & ~fault_prev));

   // Interrupt flag, set wins over clear
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         int_flag <= 1'b1;
      end else if (int_event) begin
         int_flag <= 1'b1;
      end else if (cmd_valid && carries_flags) begin
         int_flag <= 1'b0;
      end
   end

   // Answer data for the next frame
   always_comb begin
      next_data = '0;
      if (!cmd_write && cmd_addr == ssa_pkg::ADDR_SWITCH) begin
         next_data[ssa_pkg::SP_LSB +: ssa_pkg::NUM_SP] = sw_masked[ssa_pkg::NUM_SG +: ssa_pkg::NUM_SP];
         next_data[ssa_pkg::SG_LSB +: ssa_pkg::NUM_SG] = sw_masked[0 +: ssa_pkg::NUM_SG];
      end else if (cmd_addr == ssa_pkg::ADDR_ANALOG_MUX_OUTPUT) begin
         next_data[ssa_pkg::ANALOG_MUX_OUTPUT_REG_W-1:0] = analog_mux_select;
      end
      if (carries_flags) begin
         next_data[ssa_pkg::FAULT_SUM_BIT] = fault_summary;
         next_data[ssa_pkg::INT_FLAG_BIT]  = int_flag;
      end
   end

   // Answer word, shifted out in the following frame
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_word <= 32'h0000_0000;
      end else if (cmd_valid) begin
         tx_word <= {frm.rx_word[ssa_pkg::FRAME_BITS-1:ssa_pkg::HDR_LSB], next_data};
      end
   end

   // Interrupt pin, set wins over release
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         int_active <= 1'b1;
      end else if (int_event) begin
         int_active <= 1'b1;
      end else if (timer_run && timer == ssa_pkg::TIMER_W'(1)) begin
         int_active <= 1'b0;
      end
   end

   // Release timer started by chip select falling
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         timer_run <= 1'b0;
         timer     <= '0;
      end else if (frm.cs_fall && int_active && !timer_run) begin
         timer_run <= 1'b1;
         timer     <= ssa_pkg::TIMER_W'(INT_RELEASE_CYCLES);
      end else if (timer_run) begin
         timer <= timer - ssa_pkg::TIMER_W'(1);
         if (timer == ssa_pkg::TIMER_W'(1)) begin
            timer_run <= 1'b0;
         end
      end
   end

   assign int_n_o = ~int_active;
endmodule : ssa_switch_status

// >>> bench/ssa_host_model.sv
module ssa_host_model (
   // Clock
   input  wire logic clk_i,
   // Serial link
   input  wire logic miso_i,
   output logic      sclk_o,
   output logic      cs_n_o,
   output logic      mosi_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      sclk_o = 1'h0;
      cs_n_o = 1'h1;
      mosi_o = 1'h0;
   end

   // One framed transfer, MSB first, hc clocks per half period
   task automatic frame(input logic [31:0] tx, input int nb, input int hc, output logic [31:0] rx);
      rx = '0;
      @(posedge clk_i) cs_n_o <= 1'h0;
      repeat (hc) @(posedge clk_i);
      for (int i = 0; i < nb; i++) begin
         mosi_o <= tx[31-i];
         repeat (hc) @(posedge clk_i);
         sclk_o <= 1'h1;
         rx = {rx[30:0], miso_i};
         repeat (hc) @(posedge clk_i);
         sclk_o <= 1'h0;
      end
      repeat (hc) @(posedge clk_i);
      cs_n_o <= 1'h1;
      mosi_o <= ~mosi_o;
      repeat (10) @(posedge clk_i);
   endtask : frame
endmodule : ssa_host_model

// >>> bench/ssa_checker.sv
module ssa_checker #(
   parameter int unsigned INT_RELEASE_CYCLES = 50
) (
   // Clock and reset
   input wire logic                             clk_i,
   input wire logic                             rst_i,
   // Link
   input wire logic                             sclk_i,
   input wire logic                             cs_n_i,
   input wire logic                             mosi_i,
   input wire logic                             miso_o,
   input wire logic                             miso_oe_o,
   // Status and faults
   input wire logic [ssa_pkg::NUM_INPUTS-1:0]   switch_closed_i,
   input wire logic [ssa_pkg::EXT_W-1:0]        ext_status_i,
   input wire logic [ssa_pkg::WET_W-1:0]        wet_fault_i,
   input wire logic                             fault_read_o,
   // Analog mux and interrupt
   input wire logic [ssa_pkg::ANALOG_MUX_OUTPUT_CODE_W-1:0]  analog_mux_channel_o,
   input wire logic                             analog_source_choice_o,
   input wire logic                             int_n_o
);
   timeunit 1ns;
   timeprecision 100ps;

   logic [15:0] low_cnt;

   // Cycles the interrupt pin has been low
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         low_cnt <= '0;
      end else if (int_n_o) begin
         low_cnt <= '0;
      end else if (low_cnt != 16'hFFFF) begin
         low_cnt <= low_cnt + 16'h0001;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_chan_max; analog_mux_channel_o <= ssa_pkg::ANALOG_MUX_OUTPUT_CODE_MAX; endproperty
   a_chan_max: assert property (p_chan_max) else $error("channel code out of range");
   property p_chan_hold;
      $changed({analog_source_choice_o, analog_mux_channel_o}) |-> cs_n_i && $past(cs_n_i, 3);
   endproperty
   a_chan_hold: assert property (p_chan_hold) else $error("mux select changed inside frame");
   property p_oe_on; !cs_n_i [*3] |-> miso_oe_o; endproperty
   a_oe_on: assert property (p_oe_on) else $error("data out not driven in frame");
   property p_oe_off; cs_n_i [*3] |-> !miso_oe_o; endproperty
   a_oe_off: assert property (p_oe_off) else $error("data out driven outside frame");
   property p_frd_pulse; fault_read_o |=> !fault_read_o; endproperty
   a_frd_pulse: assert property (p_frd_pulse) else $error("fault read pulse too long");
   property p_frd_idle; fault_read_o |-> cs_n_i && $past(cs_n_i, 3); endproperty
   a_frd_idle: assert property (p_frd_idle) else $error("fault read inside frame");
   property p_por_int; $past(rst_i) |-> !int_n_o; endproperty
   a_por_int: assert property (p_por_int) else $error("no interrupt after reset");
   property p_rel_time; $rose(int_n_o) |-> low_cnt >= INT_RELEASE_CYCLES; endproperty
   a_rel_time: assert property (p_rel_time) else $error("interrupt released early");
   property p_sw_int; $changed(switch_closed_i) |-> ##[1:6] !int_n_o; endproperty
   a_sw_int: assert property (p_sw_int) else $error("switch change raised no interrupt");
   property p_flt_int;
      |({ext_status_i, wet_fault_i} & ~$past({ext_status_i, wet_fault_i})) |-> ##[1:4] !int_n_o;
   endproperty
   a_flt_int: assert property (p_flt_int) else $error("fault raised no interrupt");

   c_frd: cover property (fault_read_o);
   c_rel: cover property ($rose(int_n_o));
   c_chan: cover property ($changed(analog_mux_channel_o));
endmodule : ssa_checker

bind ssa_switch_status ssa_checker #(.INT_RELEASE_CYCLES(INT_RELEASE_CYCLES)) i_chk (
   .clk_i                  (clk_i),
   .rst_i                  (rst_i),
   .sclk_i                 (sclk_i),
   .cs_n_i                 (cs_n_i),
   .mosi_i                 (mosi_i),
   .miso_o                 (miso_o),
   .miso_oe_o              (miso_oe_o),
   .switch_closed_i        (switch_closed_i),
   .ext_status_i           (ext_status_i),
   .wet_fault_i            (wet_fault_i),
   .fault_read_o           (fault_read_o),
   .analog_mux_channel_o   (analog_mux_channel_o),
   .analog_source_choice_o (analog_source_choice_o),
   .int_n_o                (int_n_o)
);

// >>> bench/ssa_switch_status_bench.sv
module ssa_switch_status_bench;
   timeunit 1ns;
   timeprecision 100ps;

   logic        clk_i = 1'h0;
   logic        rst_i = 1'h1;
   logic        sclk, cs_n, mosi, miso, miso_oe, fault_read, src, int_n;
   logic [21:0] sw   = 22'h25A5C3;
   logic [10:0] ext  = '0;
   logic [21:0] wet  = '0;
   logic [5:0]  chan;
   logic [31:0] rx;
   int          err_total = 0;
   int          comparisons = 0;
   int          frd_cnt = 0;

   always #12.5 clk_i = ~clk_i;

   // Fault register read pulses seen
   always @(posedge clk_i) begin
      if (fault_read === 1'h1) begin
         frd_cnt <= frd_cnt + 1;
      end
   end

   // Undriven data line reads as the inverse of the last bit
   ssa_host_model i_host (
      .clk_i  (clk_i),
      .miso_i (miso_oe ? miso : ~miso),
      .sclk_o (sclk),
      .cs_n_o (cs_n),
      .mosi_o (mosi)
   );

   ssa_switch_status #(.INT_RELEASE_CYCLES(50)) i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
      .miso_o(miso), .miso_oe_o(miso_oe), .switch_closed_i(sw), .ext_status_i(ext),
      .wet_fault_i(wet), .fault_read_o(fault_read), .analog_mux_channel_o(chan),
      .analog_source_choice_o(src), .int_n_o(int_n)
   );

   task automatic cmd(input logic [6:0] a, input logic w, input logic [23:0] d);
      i_host.frame({a, w, d}, 32, 4, rx);
   endtask : cmd

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t word %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_pin(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t pin %b expected %b", $time, got, exp);
      end
   endtask : chk_pin

   task automatic rd_sw();
      cmd(ssa_pkg::ADDR_SWITCH, 1'h0, 24'h0);
   endtask : rd_sw

   task automatic close_out();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out

   initial begin
      #2000000;
      err_total++;
      close_out();
   end

   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'h0;
      repeat (3) @(posedge clk_i);
      chk_pin(int_n, 1'h0);
      chk({17'h0, src, chan}, 24'h0);
      rd_sw();
      rd_sw();
      chk(rx[23:0], {2'h3, sw});
      rd_sw();
      chk(rx[23:0], {2'h2, sw});
      chk_pin(int_n, 1'h1);
      cmd(ssa_pkg::ADDR_FAULT, 1'h0, 24'h0);
      rd_sw();
      rd_sw();
      chk(rx[23:0], {2'h0, sw});
      @(posedge clk_i) sw <= 22'h1A5A3C;
      repeat (8) @(posedge clk_i);
      chk_pin(int_n, 1'h0);
      rd_sw();
      rd_sw();
      chk(rx[23:0], {2'h1, 22'h1A5A3C});
      @(posedge clk_i) ext <= 11'h008;
      cmd(ssa_pkg::ADDR_LINK_CHECK, 1'h0, 24'h0);
      rd_sw();
      chk(rx[23:0], 24'h0);
      rd_sw();
      chk(rx[23:0], {2'h3, sw});
      rd_sw();
      chk(rx[23:0], {2'h2, sw});
      cmd(ssa_pkg::ADDR_FAULT, 1'h0, 24'h0);
      rd_sw();
      rd_sw();
      chk(rx[23:0], {2'h2, sw});
      @(posedge clk_i) begin
         ext <= '0;
         wet <= 22'h000020;
      end
      cmd(ssa_pkg::ADDR_WET_CFG0, 1'h0, 24'h0);
      rd_sw();
      chk(rx[23:0], 24'h0);
      rd_sw();
      chk(rx[23:0], {2'h3, sw});
      @(posedge clk_i) wet <= '0;
      cmd(ssa_pkg::ADDR_FAULT, 1'h0, 24'h0);
      rd_sw();
      rd_sw();
      chk(rx[23:0], {2'h0, sw});
      for (int c = 0; c < 24; c++) begin
         cmd(ssa_pkg::ADDR_ANALOG_MUX_OUTPUT, 1'h1, {17'h0, c[0], c[5:0]});
         chk({17'h0, src, chan}, {17'h0, c[0], (c[5:0] <= ssa_pkg::ANALOG_MUX_OUTPUT_CODE_MAX) ? c[5:0] : 6'h00});
      end
      @(posedge clk_i) sw <= 22'h3FFFFF;
      cmd(ssa_pkg::ADDR_ANALOG_MUX_OUTPUT, 1'h1, 24'h00000F);
      cmd(ssa_pkg::ADDR_ANALOG_MUX_OUTPUT, 1'h0, 24'h0);
      chk(rx[23:0], 24'h400057);
      rd_sw();
      chk(rx[23:0], 24'h00000F);
      rd_sw();
      chk(rx[23:0], 24'h3FBFFF);
      i_host.frame({ssa_pkg::ADDR_ANALOG_MUX_OUTPUT, 1'h1, 24'h0}, 31, 6, rx);
      chk({18'h0, chan}, 24'h00000F);
      chk(24'(frd_cnt), 24'h000003);
      close_out();
   end
endmodule : ssa_switch_status_bench
